// File: hdl/pixel_test_pattern_generator.sv
// Pattern generator, black-level stage, AXI4-Lite control
// Function
// - Digital black correction last, active columns
// - Pattern injected at datapath head
// - Patterns only while injection enabled
// - Select field picks one of nine patterns
// - Dark pixels take colour fill values
// - Classic value alternates even/odd columns
// - Colour field uses per-colour fill
// - Vertical colour bars emitted
// - Horizontal gradient counts active pixels
// - Vertical gradient counts active rows
// - Diagonal gradient uses same counters
// - Walking one, each row starts 1
// - Vertical bars green/blue by width
// - Horizontal bars green/blue by width
// - Outputs launched on pixel clock rise
// - Twelve-bit pixel word output
`timescale 1ns/1ps
module pixel_test_pattern_generator #(
    parameter int CBAR_W = pattern_gen_pkg::COLOR_BAR_WIDTH
) (
    // Control clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [pattern_gen_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [pattern_gen_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [pattern_gen_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [pattern_gen_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Pixel clock domain input stream
    input wire logic pix_clk,
    input wire logic [pattern_gen_pkg::PIX_W-1:0] pixel_in,
    input wire logic frame_valid_in,
    input wire logic line_valid_in,
    input wire logic dark_row_in,
    input wire logic dark_col_in,
    // Pixel output bus
    output logic [pattern_gen_pkg::PIX_W-1:0] pixel_out,
    output logic frame_valid_out,
    output logic line_valid_out
);
    import pattern_gen_pkg::*;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        cfg_type shadow;
        cfg_type xfer;
        logic req_tog;
        logic dirty;
        logic busy;
        logic [2:0] ack_sync;
        logic [2:0] fv_sync;
        logic fv_seen;
        logic aw_full;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [AXI_DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } bus_state_type;

    typedef struct packed {
        logic [2:0] rst_sync;
        logic [2:0] req_sync;
        cfg_type cfg;
        logic ack_tog;
        logic fv_prev;
        logic lv_prev;
        logic line_act;
        logic [PIX_W-1:0] col;
        logic [PIX_W-1:0] row;
        logic [PIX_W-1:0] hgrad;
        logic [PIX_W-1:0] vgrad;
        logic [PIX_W-1:0] walk;
        logic [PIX_W-1:0] vbar_cnt;
        logic vbar_par;
        logic [PIX_W-1:0] hbar_cnt;
        logic hbar_par;
        logic [PIX_W-1:0] cbar_cnt;
        logic [2:0] cbar_idx;
        logic [PIX_W-1:0] pix;
        logic fv;
        logic lv;
    } pix_state_type;

    localparam logic [PIX_W-1:0] CBAR_LAST = PIX_W'(CBAR_W - 1);

    bus_state_type bus_r;
    bus_state_type bus_nxt;
    pix_state_type pix_r;
    pix_state_type pix_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [AXI_DATA_W-1:0] merge_bytes(
        input logic [AXI_DATA_W-1:0] old,
        input logic [AXI_DATA_W-1:0] data,
        input logic [3:0] strb
    );
        logic [AXI_DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic [AXI_DATA_W-1:0] widen(input logic [PIX_W-1:0] v);
        return {{(AXI_DATA_W-PIX_W){1'b0}}, v};
    endfunction : widen

    // Bar counter step, parity flip at bar end
    function automatic logic [PIX_W:0] bar_step(
        input logic [PIX_W-1:0] cnt,
        input logic [PIX_W-1:0] width
    );
        logic [PIX_W-1:0] lim;
        lim = (width == PIX_ZERO) ? PIX_ZERO : width - 1'b1;
        if (cnt >= lim) begin
            return {1'b1, PIX_ZERO};
        end
        return {1'b0, cnt + 1'b1};
    endfunction : bar_step

    // ----------------------------------------------------------------
    // Control domain: AXI4-Lite slave and config handshake
    // ----------------------------------------------------------------
    always_comb begin
        logic [AXI_DATA_W-1:0] m;
        logic [AXI_DATA_W-1:0] ctrl_word;
        m = '0;
        bus_nxt = bus_r;
        ctrl_word = {{(AXI_DATA_W-CTRL_MODE_LSB-MODE_W){1'b0}}, bus_r.shadow.mode, 2'b00,
                     bus_r.shadow.bc_en, bus_r.shadow.en};
        bus_nxt.ack_sync = {bus_r.ack_sync[1:0], pix_r.ack_tog};
        bus_nxt.fv_sync = {bus_r.fv_sync[1:0], pix_r.fv};
        if (bus_r.fv_sync[1] == bus_r.fv_sync[2]) begin
            bus_nxt.fv_seen = bus_r.fv_sync[2];
        end
        if (awvalid && bus_r.awready) begin
            bus_nxt.aw_full = 1'b1;
            bus_nxt.aw_addr = awaddr;
        end
        if (wvalid && bus_r.wready) begin
            bus_nxt.w_full = 1'b1;
            bus_nxt.w_data = wdata;
            bus_nxt.w_strb = wstrb;
        end
        if (bus_r.bvalid && bready) begin
            bus_nxt.bvalid = 1'b0;
        end
        if (bus_nxt.aw_full && bus_nxt.w_full && !bus_nxt.bvalid) begin
            bus_nxt.aw_full = 1'b0;
            bus_nxt.w_full = 1'b0;
            bus_nxt.bvalid = 1'b1;
            bus_nxt.bresp = RESP_OKAY;
            bus_nxt.dirty = 1'b1;
            unique case (bus_nxt.aw_addr)
                OFS_CTRL: begin
                    m = merge_bytes(ctrl_word, bus_nxt.w_data, bus_nxt.w_strb);
                    bus_nxt.shadow.en = m[CTRL_EN_BIT];
                    bus_nxt.shadow.bc_en = m[CTRL_BC_BIT];
                    bus_nxt.shadow.mode = m[CTRL_MODE_LSB +: MODE_W];
                end
                OFS_GREEN: begin
                    m = merge_bytes(widen(bus_r.shadow.green), bus_nxt.w_data, bus_nxt.w_strb);
                    bus_nxt.shadow.green = m[PIX_W-1:0];
                end
                OFS_RED: begin
                    m = merge_bytes(widen(bus_r.shadow.red), bus_nxt.w_data, bus_nxt.w_strb);
                    bus_nxt.shadow.red = m[PIX_W-1:0];
                end
                OFS_BLUE: begin
                    m = merge_bytes(widen(bus_r.shadow.blue), bus_nxt.w_data, bus_nxt.w_strb);
                    bus_nxt.shadow.blue = m[PIX_W-1:0];
                end
                OFS_CLASSIC: begin
                    m = merge_bytes(widen(bus_r.shadow.classic), bus_nxt.w_data,
                                    bus_nxt.w_strb);
                    bus_nxt.shadow.classic = m[PIX_W-1:0];
                end
                OFS_BAR_WIDTH: begin
                    m = merge_bytes(widen(bus_r.shadow.bar_w), bus_nxt.w_data, bus_nxt.w_strb);
                    bus_nxt.shadow.bar_w = m[PIX_W-1:0];
                end
                OFS_BLACK_OFS: begin
                    m = merge_bytes(widen(bus_r.shadow.black_ofs), bus_nxt.w_data,
                                    bus_nxt.w_strb);
                    bus_nxt.shadow.black_ofs = m[PIX_W-1:0];
                end
                default: begin
                    bus_nxt.bresp = RESP_SLVERR;
                    bus_nxt.dirty = bus_r.dirty;
                end
            endcase
        end
        if (bus_r.rvalid && rready) begin
            bus_nxt.rvalid = 1'b0;
        end
        if (arvalid && bus_r.arready) begin
            bus_nxt.rvalid = 1'b1;
            bus_nxt.rresp = RESP_OKAY;
            unique case (araddr)
                OFS_CTRL: bus_nxt.rdata = ctrl_word;
                OFS_GREEN: bus_nxt.rdata = widen(bus_r.shadow.green);
                OFS_RED: bus_nxt.rdata = widen(bus_r.shadow.red);
                OFS_BLUE: bus_nxt.rdata = widen(bus_r.shadow.blue);
                OFS_CLASSIC: bus_nxt.rdata = widen(bus_r.shadow.classic);
                OFS_BAR_WIDTH: bus_nxt.rdata = widen(bus_r.shadow.bar_w);
                OFS_BLACK_OFS: bus_nxt.rdata = widen(bus_r.shadow.black_ofs);
                OFS_STATUS: begin
                    bus_nxt.rdata = '0;
                    bus_nxt.rdata[STAT_BUSY_BIT] = bus_r.busy | bus_r.dirty;
                    bus_nxt.rdata[STAT_FV_BIT] = bus_r.fv_seen;
                end
                default: begin
                    bus_nxt.rdata = '0;
                    bus_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        bus_nxt.awready = !bus_nxt.aw_full && !bus_nxt.bvalid;
        bus_nxt.wready = !bus_nxt.w_full && !bus_nxt.bvalid;
        bus_nxt.arready = !bus_nxt.rvalid;
        // Config handshake, xfer held until acked
        if (bus_r.busy && bus_r.ack_sync[1] == bus_r.ack_sync[2]
            && bus_r.ack_sync[2] == bus_r.req_tog) begin
            bus_nxt.busy = 1'b0;
        end
        if (!bus_r.busy && bus_r.dirty) begin
            bus_nxt.xfer = bus_r.shadow;
            bus_nxt.req_tog = !bus_r.req_tog;
            bus_nxt.busy = 1'b1;
            bus_nxt.dirty = bus_nxt.dirty && (bus_nxt.shadow != bus_r.shadow);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_r <= '{shadow: CFG_RST, xfer: CFG_RST, bresp: RESP_OKAY, rresp: RESP_OKAY,
                       default: '0};
        end else begin
            bus_r <= bus_nxt;
        end
    end

    assign awready = bus_r.awready;
    assign wready = bus_r.wready;
    assign bvalid = bus_r.bvalid;
    assign bresp = bus_r.bresp;
    assign arready = bus_r.arready;
    assign rvalid = bus_r.rvalid;
    assign rdata = bus_r.rdata;
    assign rresp = bus_r.rresp;

    // ----------------------------------------------------------------
    // Pixel domain: counters, pattern mux, black correction
    // ----------------------------------------------------------------
    always_comb begin
        logic pix_rstn;
        logic line_start;
        logic frame_start;
        logic line_end;
        logic active;
        logic is_red;
        logic is_blue;
        logic [PIX_W-1:0] fill;
        logic [PIX_W-1:0] c_col;
        logic [PIX_W-1:0] c_hgrad;
        logic [PIX_W-1:0] c_walk;
        logic [PIX_W-1:0] c_vbar;
        logic c_vpar;
        logic [PIX_W-1:0] c_cbar;
        logic [2:0] c_cidx;
        logic [2:0] rgb;
        logic [PIX_W:0] step;
        logic [PIX_W-1:0] val;
        logic signed [PIX_W+1:0] sum;
        step = '0;
        pix_nxt = pix_r;
        pix_nxt.rst_sync = {pix_r.rst_sync[1:0], aresetn};
        pix_nxt.req_sync = {pix_r.req_sync[1:0], bus_r.req_tog};
        pix_rstn = pix_r.rst_sync[1] | pix_r.rst_sync[2];
        line_start = line_valid_in && !pix_r.lv_prev;
        line_end = !line_valid_in && pix_r.lv_prev;
        frame_start = frame_valid_in && !pix_r.fv_prev;
        active = line_valid_in && !dark_row_in && !dark_col_in;
        // Per-row counters restart at row start
        c_col = line_start ? PIX_ZERO : pix_r.col;
        c_hgrad = line_start ? PIX_ZERO : pix_r.hgrad;
        c_walk = line_start ? WALK_FIRST : pix_r.walk;
        c_vbar = line_start ? PIX_ZERO : pix_r.vbar_cnt;
        c_vpar = line_start ? 1'b0 : pix_r.vbar_par;
        c_cbar = line_start ? PIX_ZERO : pix_r.cbar_cnt;
        c_cidx = line_start ? 3'd0 : pix_r.cbar_idx;
        // Bayer site: even rows G/R, odd rows B/G
        is_red = !pix_r.row[0] && c_col[0];
        is_blue = pix_r.row[0] && !c_col[0];
        fill = is_red ? pix_r.cfg.red : (is_blue ? pix_r.cfg.blue : pix_r.cfg.green);
        rgb = CBAR_RGB[c_cidx*3 +: 3];
        val = pixel_in;
        if (pix_r.cfg.en) begin
            if (!active) begin
                val = fill;
            end else begin
                unique case (pix_r.cfg.mode)
                    MODE_COLOR_FIELD: val = fill;
                    MODE_HGRAD: val = c_hgrad;
                    MODE_VGRAD: val = pix_r.vgrad;
                    MODE_DGRAD: val = c_hgrad + pix_r.vgrad;
                    MODE_CLASSIC: val = c_col[0] ? ~pix_r.cfg.classic : pix_r.cfg.classic;
                    MODE_WALK: val = c_walk;
                    MODE_HBARS: val = pix_r.hbar_par ? pix_r.cfg.blue : pix_r.cfg.green;
                    MODE_VBARS: val = c_vpar ? pix_r.cfg.blue : pix_r.cfg.green;
                    MODE_CBARS: begin
                        val = (is_red ? rgb[2] : (is_blue ? rgb[0] : rgb[1])) ? PIX_MAX
                                                                            : PIX_ZERO;
                    end
                    default: val = fill;
                endcase
            end
        end
        // Black correction last, active columns
        sum = $signed({2'b00, val}) + $signed({{2{pix_r.cfg.black_ofs[PIX_W-1]}},
                                               pix_r.cfg.black_ofs});
        if (pix_r.cfg.bc_en && !dark_col_in) begin
            if (sum < 0) begin
                val = PIX_ZERO;
            end else if (sum > $signed({2'b00, PIX_MAX})) begin
                val = PIX_MAX;
            end else begin
                val = sum[PIX_W-1:0];
            end
        end
        pix_nxt.pix = line_valid_in ? val : PIX_ZERO;
        pix_nxt.fv = frame_valid_in;
        pix_nxt.lv = line_valid_in;
        pix_nxt.fv_prev = frame_valid_in;
        pix_nxt.lv_prev = line_valid_in;
        // Counter advance
        if (line_valid_in) begin
            pix_nxt.col = c_col + 1'b1;
            pix_nxt.hgrad = c_hgrad;
            pix_nxt.walk = c_walk;
            pix_nxt.vbar_cnt = c_vbar;
            pix_nxt.vbar_par = c_vpar;
            pix_nxt.cbar_cnt = c_cbar;
            pix_nxt.cbar_idx = c_cidx;
            pix_nxt.line_act = line_start ? active : (pix_r.line_act | active);
            if (active) begin
                pix_nxt.hgrad = c_hgrad + 1'b1;
                pix_nxt.walk = {c_walk[PIX_W-2:0], c_walk[PIX_W-1]};
                step = bar_step(c_vbar, pix_r.cfg.bar_w);
                pix_nxt.vbar_cnt = step[PIX_W-1:0];
                pix_nxt.vbar_par = c_vpar ^ step[PIX_W];
                if (c_cbar >= CBAR_LAST) begin
                    pix_nxt.cbar_cnt = PIX_ZERO;
                    pix_nxt.cbar_idx = c_cidx + 3'd1;
                end else begin
                    pix_nxt.cbar_cnt = c_cbar + 1'b1;
                end
            end
        end
        if (line_end) begin
            pix_nxt.row = pix_r.row + 1'b1;
            if (pix_r.line_act) begin
                pix_nxt.vgrad = pix_r.vgrad + 1'b1;
                step = bar_step(pix_r.hbar_cnt, pix_r.cfg.bar_w);
                pix_nxt.hbar_cnt = step[PIX_W-1:0];
                pix_nxt.hbar_par = pix_r.hbar_par ^ step[PIX_W];
            end
        end
        if (frame_start) begin
            pix_nxt.row = PIX_ZERO;
            pix_nxt.vgrad = PIX_ZERO;
            pix_nxt.hbar_cnt = PIX_ZERO;
            pix_nxt.hbar_par = 1'b0;
        end
        // Config taken once request toggle settles
        if (pix_r.req_sync[1] == pix_r.req_sync[2] && pix_r.req_sync[2] != pix_r.ack_tog) begin
            pix_nxt.cfg = bus_r.xfer;
            pix_nxt.ack_tog = pix_r.req_sync[2];
        end
        if (!pix_rstn) begin
            pix_nxt = '{rst_sync: pix_nxt.rst_sync, req_sync: pix_nxt.req_sync, cfg: CFG_RST,
                        walk: WALK_FIRST, default: '0};
        end
    end

    always_ff @(posedge pix_clk) begin
        pix_r <= pix_nxt;
    end

    assign pixel_out = pix_r.pix;
    assign frame_valid_out = pix_r.fv;
    assign line_valid_out = pix_r.lv;

endmodule : pixel_test_pattern_generator

// File: inc/pattern_gen_pkg.sv
// Constants, register map and types for the pixel test pattern generator
package pattern_gen_pkg;

    // ----------------------------------------------------------------
    // Pixel and bus widths
    // ----------------------------------------------------------------
    localparam int PIX_W = 12;
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;
    localparam logic [PIX_W-1:0] PIX_ZERO = 12'h000;
    localparam logic [PIX_W-1:0] WALK_FIRST = 12'h001;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_GREEN = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_RED = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_BLUE = 8'h0c;
    localparam logic [AXI_ADDR_W-1:0] OFS_CLASSIC = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFS_BAR_WIDTH = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFS_BLACK_OFS = 8'h18;
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h1c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BC_BIT = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int MODE_W = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FV_BIT = 1;

    // ----------------------------------------------------------------
    // Pattern select codes
    // ----------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_COLOR_FIELD = 4'h0;
    localparam logic [MODE_W-1:0] MODE_HGRAD = 4'h1;
    localparam logic [MODE_W-1:0] MODE_VGRAD = 4'h2;
    localparam logic [MODE_W-1:0] MODE_DGRAD = 4'h3;
    localparam logic [MODE_W-1:0] MODE_CLASSIC = 4'h4;
    localparam logic [MODE_W-1:0] MODE_WALK = 4'h5;
    localparam logic [MODE_W-1:0] MODE_HBARS = 4'h6;
    localparam logic [MODE_W-1:0] MODE_VBARS = 4'h7;
    localparam logic [MODE_W-1:0] MODE_CBARS = 4'h8;

    // ----------------------------------------------------------------
    // Reset values and responses
    // ----------------------------------------------------------------
    localparam logic [PIX_W-1:0] BAR_WIDTH_RST = 12'h008;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int COLOR_BAR_WIDTH = 256;

    // Eight bars, 3 bits each {r,g,b}: white..black
    localparam logic [23:0] CBAR_RGB = 24'b000_001_100_101_010_011_110_111;

    typedef struct packed {
        logic en;
        logic bc_en;
        logic [MODE_W-1:0] mode;
        logic [PIX_W-1:0] green;
        logic [PIX_W-1:0] red;
        logic [PIX_W-1:0] blue;
        logic [PIX_W-1:0] classic;
        logic [PIX_W-1:0] bar_w;
        logic [PIX_W-1:0] black_ofs;
    } cfg_type;

    localparam cfg_type CFG_RST = '{
        en: 1'b0, bc_en: 1'b0, mode: MODE_COLOR_FIELD, green: PIX_ZERO,
        red: PIX_ZERO, blue: PIX_ZERO, classic: PIX_ZERO,
        bar_w: BAR_WIDTH_RST, black_ofs: PIX_ZERO};

endpackage : pattern_gen_pkg

// File: verification/pattern_gen_assertions.sv
// Port-level checks for the pattern generator
`timescale 1ns/1ps
module pattern_gen_assertions (
    // Control domain
    input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
    input wire logic bvalid, bready, arvalid, arready, rvalid, rready,
    // Pixel domain
    input wire logic pix_clk, frame_valid_in, line_valid_in,
    input wire logic [pattern_gen_pkg::PIX_W-1:0] pixel_out,
    input wire logic frame_valid_out, line_valid_out
);
    sequence s_wr; awvalid && awready && wvalid && wready; endsequence
    sequence s_bhs; bvalid && bready; endsequence
    property p_wr; @(posedge aclk) disable iff (!aresetn)
        s_wr |=> bvalid && !awready && !wready; endproperty
    a_wr: assert property (p_wr) else $error("no write response");
    property p_bhs; @(posedge aclk) disable iff (!aresetn)
        s_bhs |=> !bvalid && awready && wready; endproperty
    a_bhs: assert property (p_bhs) else $error("write not closed");
    property p_rd; @(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid && !arready; endproperty
    a_rd: assert property (p_rd) else $error("no read data");
    property p_rhs; @(posedge aclk) disable iff (!aresetn)
        rvalid && rready |=> !rvalid && arready; endproperty
    a_rhs: assert property (p_rhs) else $error("read not closed");
    property p_fv; @(posedge pix_clk) disable iff (!aresetn)
        frame_valid_out == $past(frame_valid_in); endproperty
    a_fv: assert property (p_fv) else $error("frame valid late");
    property p_lv; @(posedge pix_clk) disable iff (!aresetn)
        line_valid_out == $past(line_valid_in); endproperty
    a_lv: assert property (p_lv) else $error("line valid late");
    property p_zero; @(posedge pix_clk) disable iff (!aresetn)
        !$past(line_valid_in) |-> pixel_out == 12'h000; endproperty
    a_zero: assert property (p_zero) else $error("pixel outside line");
    property p_nest; @(posedge pix_clk) disable iff (!aresetn)
        line_valid_out |-> frame_valid_out; endproperty
    a_nest: assert property (p_nest) else $error("line outside frame");
endmodule : pattern_gen_assertions

// File: verification/pixel_receiver_model.sv
// Receiver model capturing the pixel bus
`timescale 1ns/1ps
module pixel_receiver_model (
    // Link side
    input wire logic pix_clk,
    input wire logic [pattern_gen_pkg::PIX_W-1:0] pix,
    input wire logic fv,
    input wire logic lv,
    // Captured values
    output logic [pattern_gen_pkg::PIX_W-1:0] cap_pix,
    output logic cap_fv,
    output logic cap_lv
);
    always @(negedge pix_clk) begin
        cap_pix <= pix;
        cap_fv <= fv;
        cap_lv <= lv;
    end
endmodule : pixel_receiver_model

// File: verification/tb_pixel_test_pattern_generator.sv
// Self-checking bench for the pixel test pattern generator
`timescale 1ns/1ps
module tb_pixel_test_pattern_generator;
    import pattern_gen_pkg::*;
    localparam int CB = 2;
    logic aclk = 0, aresetn = 0, pix_clk = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, frame_valid_in = 0, line_valid_in = 0;
    logic dark_row_in = 0, dark_col_in = 0, en = 0, bc = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, d, rdata;
    logic [3:0] wstrb = 0;
    logic [2:0] awprot = 0, arprot = 0;
    logic [11:0] pixel_in = 0, grn, red, blu, cls, bw, ofs = 0, pixel_out, cap_pix;
    logic awready, wready, bvalid, arready, rvalid, frame_valid_out, line_valid_out;
    logic cap_fv, cap_lv;
    logic [1:0] bresp, rresp, rs;
    logic [13:0] q[$];
    int mode, fail_count = 0, check_count = 0, cyc = 0, seed = 32'h0472_1fc5;
    pixel_test_pattern_generator #(.CBAR_W(CB)) i_pixel_test_pattern_generator (.*);
    pixel_receiver_model i_pixel_receiver_model (.pix_clk, .pix(pixel_out),
        .fv(frame_valid_out), .lv(line_valid_out), .cap_pix, .cap_fv, .cap_lv);
    initial forever #50 aclk = ~aclk;
    initial #17 forever #62.5 pix_clk = ~pix_clk;
    task chk(input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: saw %h, want %h", $time, s, e);
        end
    endtask : chk
    task complete_run;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    task wr(input logic [7:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] e);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, v, s};
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 50 && !bvalid; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        bready <= 0;
        chk(bresp, e);
    endtask : wr
    task cfg(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, 4'hf, RESP_OKAY);
    endtask : cfg
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int n = 0; n < 50 && !rvalid; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        rready <= 0;
        d = rdata;
        rs = rresp;
    endtask : rd
    task settle;
        d = 1;
        for (int n = 0; n < 40 && d[0]; n++) rd(OFS_STATUS);
        chk(d[0], 0);
    endtask : settle
    function automatic logic [11:0] pat(int r, c, ai, ar, logic [11:0] p, logic dk, dc);
        int k;
        logic [11:0] v;
        logic signed [13:0] s;
        k = 1 + c % 2 - r % 2;
        if (!en) v = p;
        else if (dk || mode > 8 || mode == 0) v = k == 2 ? red : k == 1 ? grn : blu;
        else case (mode)
            1: v = 12'(ai);
            2: v = 12'(ar);
            3: v = 12'(ai + ar);
            4: v = c % 2 ? ~cls : cls;
            5: v = 12'h001 << (ai % 12);
            6: v = (ar / bw) % 2 ? blu : grn;
            7: v = (ai / bw) % 2 ? blu : grn;
            default: v = CBAR_RGB[(ai / CB % 8) * 3 + k] ? PIX_MAX : PIX_ZERO;
        endcase
        s = $signed({2'b00, v}) + $signed(ofs);
        if (bc && !dc) v = s < 0 ? 12'h000 : s > 4095 ? 12'hfff : s[11:0];
        return v;
    endfunction : pat
    task step(input logic f, l, dk, dc, input logic [11:0] p, v);
        @(posedge pix_clk);
        if (q.size() == 2) chk({cap_fv, cap_lv, cap_pix}, q.pop_front());
        {frame_valid_in, line_valid_in, dark_row_in, dark_col_in, pixel_in} <= {f, l, dk, dc, p};
        q.push_back({f, l, l ? v : 12'h000});
    endtask : step
    task automatic frame;
        logic [11:0] p;
        int ar = 0;
        int ai;
        step(1, 0, 0, 0, 0, 0);
        for (int r = 0; r < 4; r++) begin
            ai = 0;
            for (int c = 0; c < 16; c++) begin
                p = 12'($random(seed));
                step(1, 1, r == 0, c < 2, p, pat(r, c, ai, ar, p, r == 0 || c < 2, c < 2));
                if (r > 0 && c >= 2) ai++;
            end
            step(1, 0, 0, 0, 0, 0);
            if (r > 0) ar++;
        end
        repeat (2) step(0, 0, 0, 0, 0, 0);
        $display("frame done, mode %0d", mode);
    endtask : frame
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_CTRL);
        chk(d, 0);
        rd(OFS_BAR_WIDTH);
        chk(d, 32'h0000_0008);
        wr(OFS_GREEN, 32'h1234_5abc, 4'b0001, RESP_OKAY);
        rd(OFS_GREEN);
        chk(d, 32'h0000_00bc);
        wr(8'h20, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        wr(OFS_STATUS, 0, 4'hf, RESP_SLVERR);
        rd(8'h20);
        chk(rs, RESP_SLVERR);
        chk(d, 32'h0000_0000);
        {grn, red, blu, cls, bw} = {48'({$random(seed), $random(seed)}), 12'h002};
        cfg(OFS_GREEN, grn);
        cfg(OFS_RED, red);
        cfg(OFS_BLUE, blu);
        cfg(OFS_CLASSIC, cls);
        cfg(OFS_BAR_WIDTH, bw);
        en = 1;
        for (mode = 0; mode < 10; mode++) begin
            cfg(OFS_CTRL, 32'((mode << 4) | 1));
            settle;
            frame;
        end
        {mode, bc, ofs} = {32'd1, 1'b1, 12'hffd};
        cfg(OFS_BLACK_OFS, ofs);
        cfg(OFS_CTRL, 32'h0000_0013);
        settle;
        frame;
        en = 0;
        cfg(OFS_CTRL, 32'h0000_0002);
        settle;
        frame;
        complete_run;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run;
        end
    end
endmodule : tb_pixel_test_pattern_generator
bind pixel_test_pattern_generator pattern_gen_assertions i_pattern_gen_assertions (.aclk,
    .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
    .arready, .rvalid, .rready, .pix_clk, .frame_valid_in, .line_valid_in, .pixel_out,
    .frame_valid_out, .line_valid_out);
